// *** hw/dsu_pkg.sv ***
package dsu_pkg;
	// ==================================================
	// Clock and timing
	// ==================================================
	localparam int CLK_HZ = 10_000_000; // System clock rate
	localparam int CLK_NS = 100; // System clock period
	localparam int SEEK_TO_MS = 500; // Move limit, single density
	localparam int SEEK_TO_DD_MS = 575; // Move limit, double density (nominal)
	localparam int SEEK_CYC = SEEK_TO_MS * (CLK_HZ / 1000); // Longest time, rounds down
	localparam int SEEK_DD_CYC = SEEK_TO_DD_MS * (CLK_HZ / 1000);
	localparam int AMP_NS = 5000; // Least stretch of amplitude dips
	localparam int AMP_CYC = (AMP_NS + CLK_NS - 1) / CLK_NS; // Rounds up
	localparam int WCLK_HZ = 6_451_000; // Write clock, double density
	localparam int WCLK_RAW = CLK_HZ / (2 * WCLK_HZ);
	localparam int WCLK_HALF = (WCLK_RAW < 1) ? 1 : WCLK_RAW; // Half period in cycles
	localparam int SC_SETTLE = 2; // Cycles the sector count reads as changing

	// ==================================================
	// Widths and counts
	// ==================================================
	localparam int BUS_W = 9; // Status and data bus width
	localparam int SECT_W = 5;
	localparam int HEAD_W = 5;
	localparam int TMR_W = 23;
	localparam int AMP_W = 6;
	localparam int FR_W = 8; // Fault register width
	localparam int SECT_NUM = 24; // Sectors per revolution
	localparam int HEAD_LAST = 18; // Highest head before end of cylinder

	// ==================================================
	// Bit positions
	// ==================================================
	localparam int SC_VALID_BIT = 8;
	localparam int PS_FWD = 0, PS_REV = 1, PS_CYL = 2, PS_EOT = 3, PS_FINE = 4, PS_SPEED = 5;
	localparam int FR_OFFCYL = 0, FR_WRREAD = 1, FR_CURR = 2, FR_PVOLT = 3;
	localparam int FR_NVOLT = 4, FR_SEEK = 5, FR_ACWR = 6;
	localparam int CS_SMARK = 0, CS_UNSAFE = 1, CS_SEEKERR = 2, CS_ONCYL = 3;
	localparam int CS_INDEX = 4, CS_AMP1 = 5, CS_EOC = 6, CS_AMP2 = 7, CS_AMP3 = 8;

	// ==================================================
	// Types
	// ==================================================
	typedef logic [TMR_W-1:0] dsu_tmr_t;
	typedef logic [SECT_W-1:0] dsu_sect_t;
	typedef logic [HEAD_W-1:0] dsu_head_t;
	typedef logic [AMP_W-1:0] dsu_amp_t;
	typedef logic [BUS_W-1:0] dsu_word_t;
	typedef logic [FR_W-1:0] dsu_fault_t;
	typedef logic [1:0] dsu_hold_t;
	typedef logic [AMP_W-1:0] dsu_wclk_t;

	typedef enum logic [1:0] {RES_FREE, RES_OURS, RES_OPP} dsu_res_t;
	typedef enum logic {SK_IDLE, SK_MOVE} dsu_seek_t;

	// All pin inputs, controller side then drive side
	typedef struct packed {
		logic unit_sel;
		logic rel_req;
		logic dis_opp;
		logic opp_sel;
		logic opp_rel;
		logic clr_fault;
		logic sel_sc;
		logic sel_sr;
		logic sel_ps;
		logic sel_fs;
		logic sel_cs;
		logic wgate;
		logic rgate;
		logic egate;
		logic seek;
		logic rtz;
		logic head_adv;
		logic wstrobe;
		logic wdat_line;
		logic sect_pulse;
		logic index;
		logic cyl_pulse;
		logic move_done;
		logic eot;
		logic fine;
		logic speed;
		logic fwd;
		logic multi_head;
		logic erase_drv;
		logic write_drv;
		logic both_wdrv;
		logic wdata;
		logic pvolt;
		logic nvolt;
		logic amp1;
		logic amp2;
		logic amp3;
		logic unload;
		logic spin_off;
		logic online;
		logic rd_pulse;
		logic ref_clk;
		logic dd;
		dsu_sect_t sect_reg;
	} dsu_pins_t;

	// Whole state of the unit interface
	typedef struct packed {
		dsu_pins_t s1;
		dsu_pins_t s2;
		dsu_pins_t p;
		dsu_res_t res;
		dsu_seek_t seek;
		dsu_tmr_t tmr;
		logic ready;
		logic on_cyl;
		logic seek_err;
		logic eot_err;
		dsu_fault_t fault;
		dsu_sect_t sect_cnt;
		dsu_hold_t sc_hold;
		dsu_head_t head_cnt;
		dsu_amp_t amp2_cnt;
		dsu_amp_t amp3_cnt;
		dsu_wclk_t wclk_cnt;
		logic wclk;
		logic wbit;
		logic rdat;
		logic rclk;
		logic seek_go;
		logic rtz_go;
		logic selected;
		dsu_word_t stat;
		dsu_word_t data;
	} dsu_state_t;
endpackage

// *** hw/dsu_unit_if.sv ***
// Local design decisions: strobed register access and the placing of the registers.
module dsu_unit_if #(
	parameter int SEEK_CYC_P = dsu_pkg::SEEK_CYC,
	parameter int SEEK_DD_CYC_P = dsu_pkg::SEEK_DD_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire dsu_pkg::dsu_pins_t pins,
	output logic [dsu_pkg::BUS_W-1:0] status_bus,
	output logic [dsu_pkg::BUS_W-1:0] data_bus,
	output logic unit_ready,
	output logic unit_busy,
	output logic unit_selected,
	output logic on_line,
	output logic read_data,
	output logic ref_clock,
	output logic write_clock,
	output logic write_bit,
	output logic dd_unit,
	output logic seek_go,
	output logic rtz_go
);
	// ==================================================
	// State and helpers
	// ==================================================
	dsu_pkg::dsu_state_t r; // Registered state
	dsu_pkg::dsu_state_t n; // Next state
	dsu_pkg::dsu_tmr_t seek_lim; // Last cycle of a legal move
	localparam int AMP_HOLD = dsu_pkg::AMP_CYC;

	// Rising edge of a synchronised level
	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	// Move limit depends on density
	assign seek_lim = r.s2.dd ? dsu_pkg::dsu_tmr_t'(SEEK_DD_CYC_P - 1) :
		dsu_pkg::dsu_tmr_t'(SEEK_CYC_P - 1);

	// ==================================================
	// Next state
	// ==================================================
	always_comb begin
		n = r;
		// Two stages for every pin; the sector register word may
		// tear while it changes, so the controller reads it settled
		n.s1 = pins;
		n.s2 = r.s1;
		n.p = r.s2;
		n.seek_go = 1'b0;
		n.rtz_go = 1'b0;

		// Heads unloaded with spindle stopped; dropped before the
		// move logic so a completion in the same cycle still wins
		if (r.s2.unload && r.s2.spin_off) begin
			n.ready = 1'b0;
		end

		// Positioner sequencing
		unique case (r.seek)
			dsu_pkg::SK_IDLE: begin
				if (rise(r.s2.rtz, r.p.rtz)) begin
					// Zero seek always taken: it is the first seek
					n.seek = dsu_pkg::SK_MOVE;
					n.tmr = '0;
					n.on_cyl = 1'b0;
					n.seek_err = 1'b0;
					n.eot_err = 1'b0;
					n.rtz_go = 1'b1;
				end else if (rise(r.s2.seek, r.p.seek) && r.ready) begin
					// Ordinary seeks are taken only while ready, else ignored
					n.seek = dsu_pkg::SK_MOVE;
					n.tmr = '0;
					n.on_cyl = 1'b0;
					n.seek_go = 1'b1;
				end
			end
			dsu_pkg::SK_MOVE: begin
				n.tmr = dsu_pkg::dsu_tmr_t'(r.tmr + 1'b1);
				if (rise(r.s2.move_done, r.p.move_done)) begin
					// Move finished in time
					n.seek = dsu_pkg::SK_IDLE;
					n.on_cyl = 1'b1;
					n.ready = 1'b1;
				end else if (r.tmr == seek_lim) begin
					// Move ran out of time
					n.seek = dsu_pkg::SK_IDLE;
					n.seek_err = 1'b1;
				end
			end
		endcase
		// Carriage outside field; set wins over the zero-seek clear
		if (r.s2.eot) begin
			n.seek_err = 1'b1;
			n.eot_err = 1'b1;
		end

		// Fault register: clear first so a same-cycle event survives
		if (r.s2.clr_fault && r.selected) begin
			n.fault = '0;
		end
		if ((rise(r.s2.wgate, r.p.wgate) || rise(r.s2.rgate, r.p.rgate) ||
			(rise(r.s2.egate, r.p.egate) && !r.s2.dd)) && !r.on_cyl) begin
			n.fault[dsu_pkg::FR_OFFCYL] = 1'b1;
		end
		if ((rise(r.s2.wgate, r.p.wgate) ||
			(rise(r.s2.egate, r.p.egate) && !r.s2.dd)) && r.s2.rgate) begin
			n.fault[dsu_pkg::FR_WRREAD] = 1'b1;
		end
		// Double density has no erase driver, so pairing is skipped
		if (r.s2.multi_head || r.s2.both_wdrv || (r.s2.wgate && !r.s2.wdata) ||
			(!r.s2.dd && (r.s2.erase_drv ^ r.s2.write_drv))) begin
			n.fault[dsu_pkg::FR_CURR] = 1'b1;
		end
		if (r.s2.pvolt) begin
			n.fault[dsu_pkg::FR_PVOLT] = 1'b1;
		end
		if (r.s2.nvolt) begin
			n.fault[dsu_pkg::FR_NVOLT] = 1'b1;
		end
		if (r.seek_err) begin
			n.fault[dsu_pkg::FR_SEEK] = 1'b1;
		end
		if (r.s2.dd && r.s2.wgate && !r.s2.wdata) begin
			n.fault[dsu_pkg::FR_ACWR] = 1'b1;
		end

		// Sector counter, one ahead of the heads
		if (r.sc_hold != '0) begin
			n.sc_hold = dsu_pkg::dsu_hold_t'(r.sc_hold - 1'b1);
		end
		if (rise(r.s2.index, r.p.index)) begin
			// Index marks sector zero, so show sector one
			n.sect_cnt = dsu_pkg::dsu_sect_t'(1);
			n.sc_hold = dsu_pkg::dsu_hold_t'(dsu_pkg::SC_SETTLE);
		end else if (rise(r.s2.sect_pulse, r.p.sect_pulse)) begin
			if (r.sect_cnt == dsu_pkg::dsu_sect_t'(dsu_pkg::SECT_NUM - 1)) begin
				n.sect_cnt = '0;
			end else begin
				n.sect_cnt = dsu_pkg::dsu_sect_t'(r.sect_cnt + 1'b1);
			end
			n.sc_hold = dsu_pkg::dsu_hold_t'(dsu_pkg::SC_SETTLE);
		end

		// Head counter; an advance while already beyond the last head wraps it
		if (rise(r.s2.head_adv, r.p.head_adv)) begin
			if (r.head_cnt > dsu_pkg::dsu_head_t'(dsu_pkg::HEAD_LAST)) begin
				n.head_cnt = '0;
			end else begin
				n.head_cnt = dsu_pkg::dsu_head_t'(r.head_cnt + 1'b1);
			end
		end

		// Pulse stretchers for short amplitude dips
		if (rise(r.s2.amp2, r.p.amp2)) begin
			n.amp2_cnt = dsu_pkg::dsu_amp_t'(dsu_pkg::AMP_CYC);
		end else if (r.amp2_cnt != '0) begin
			n.amp2_cnt = dsu_pkg::dsu_amp_t'(r.amp2_cnt - 1'b1);
		end
		if (rise(r.s2.amp3, r.p.amp3)) begin
			n.amp3_cnt = dsu_pkg::dsu_amp_t'(dsu_pkg::AMP_CYC);
		end else if (r.amp3_cnt != '0) begin
			n.amp3_cnt = dsu_pkg::dsu_amp_t'(r.amp3_cnt - 1'b1);
		end

		// Reservation between the two channels
		if ((r.s2.unit_sel || r.selected) && r.s2.rel_req && r.res == dsu_pkg::RES_OURS) begin
			n.res = dsu_pkg::RES_FREE;
		end
		if ((r.s2.dis_opp || r.s2.opp_rel) && r.res == dsu_pkg::RES_OPP) begin
			n.res = dsu_pkg::RES_FREE;
		end
		if (n.res == dsu_pkg::RES_FREE) begin
			// Select with release: served but left unreserved
			if (r.s2.unit_sel && r.s2.online && !r.s2.rel_req) begin
				n.res = dsu_pkg::RES_OURS;
			end else if (r.s2.opp_sel && !r.s2.dis_opp && !r.s2.unit_sel) begin
				n.res = dsu_pkg::RES_OPP;
			end
		end
		n.selected = r.s2.unit_sel && r.s2.online && (n.res != dsu_pkg::RES_OPP);

		// Status and data buses, only while selected
		n.stat = '0;
		n.data = '0;
		if (r.selected) begin
			// First select wins should two arrive together
			if (r.s2.sel_sc) begin
				n.stat[dsu_pkg::SECT_W-1:0] = r.sect_cnt;
				n.stat[dsu_pkg::SC_VALID_BIT] = (r.sc_hold == '0);
			end else if (r.s2.sel_fs) begin
				n.stat[dsu_pkg::FR_W-1:0] = r.fault;
			end else if (r.s2.sel_cs) begin
				n.stat[dsu_pkg::CS_SMARK] = r.s2.sect_pulse;
				n.stat[dsu_pkg::CS_UNSAFE] = |r.fault;
				n.stat[dsu_pkg::CS_SEEKERR] = r.seek_err;
				n.stat[dsu_pkg::CS_ONCYL] = r.on_cyl;
				n.stat[dsu_pkg::CS_INDEX] = r.s2.index;
				n.stat[dsu_pkg::CS_AMP1] = r.s2.dd ? r.eot_err : r.s2.amp1;
				n.stat[dsu_pkg::CS_EOC] = r.head_cnt > dsu_pkg::dsu_head_t'(dsu_pkg::HEAD_LAST);
				n.stat[dsu_pkg::CS_AMP2] = (r.amp2_cnt != '0) && !r.s2.dd;
				n.stat[dsu_pkg::CS_AMP3] = (r.amp3_cnt != '0) && !r.s2.dd;
			end
			if (r.s2.sel_sr) begin
				// The word is synchronised bit by bit and may tear; only
				// one that stood for a cycle is passed, else the last one
				if (r.s2.sect_reg == r.p.sect_reg) begin
					n.data[dsu_pkg::SECT_W-1:0] = r.s2.sect_reg;
				end else begin
					n.data[dsu_pkg::SECT_W-1:0] = r.data[dsu_pkg::SECT_W-1:0];
				end
			end else if (r.s2.sel_ps) begin
				n.data[dsu_pkg::PS_FWD] = r.s2.fwd;
				n.data[dsu_pkg::PS_REV] = !r.s2.fwd;
				n.data[dsu_pkg::PS_CYL] = r.s2.cyl_pulse && (r.seek == dsu_pkg::SK_MOVE);
				n.data[dsu_pkg::PS_EOT] = r.s2.eot;
				n.data[dsu_pkg::PS_FINE] = r.s2.fine;
				n.data[dsu_pkg::PS_SPEED] = r.s2.speed;
			end
		end

		// Serial data paths
		n.rdat = r.s2.rd_pulse && r.s2.rgate;
		n.rclk = r.s2.ref_clk;
		if (!r.s2.dd) begin
			n.wbit = r.s2.wdat_line;
		end else if (rise(r.s2.wstrobe, r.p.wstrobe)) begin
			n.wbit = r.s2.wdat_line;
		end
		// Write clock from a divider; the rate is bounded by clk
		if (!r.s2.dd) begin
			n.wclk = 1'b0;
			n.wclk_cnt = '0;
		end else if (r.wclk_cnt == dsu_pkg::dsu_wclk_t'(dsu_pkg::WCLK_HALF - 1)) begin
			n.wclk = !r.wclk;
			n.wclk_cnt = '0;
		end else begin
			n.wclk_cnt = dsu_pkg::dsu_wclk_t'(r.wclk_cnt + 1'b1);
		end
	end

	// ==================================================
	// State register
	// ==================================================
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ==================================================
	// Outputs
	// ==================================================
	assign status_bus = r.stat;
	assign data_bus = r.data;
	assign unit_ready = r.ready;
	assign unit_busy = (r.res == dsu_pkg::RES_OPP);
	assign unit_selected = r.selected;
	assign on_line = r.s2.online;
	assign read_data = r.rdat;
	assign ref_clock = r.rclk;
	assign write_clock = r.wclk;
	assign write_bit = r.wbit;
	assign dd_unit = r.s2.dd;
	assign seek_go = r.seek_go;
	assign rtz_go = r.rtz_go;

	// ==================================================
	// Checks
	// ==================================================
	a_sc_valid: assert property (@(posedge clk) disable iff (!rstn)
		(rise(r.s2.sect_pulse, r.p.sect_pulse) ##1 (r.s2.sel_sc && r.selected))
		|=> !status_bus[dsu_pkg::SC_VALID_BIT])
		else $error("sector count shown valid while changing");

	a_sect_lead: assert property (@(posedge clk) disable iff (!rstn)
		rise(r.s2.index, r.p.index) |=> (r.sect_cnt == dsu_pkg::dsu_sect_t'(1)))
		else $error("sector count does not lead index by one");

	a_gate_offcyl: assert property (@(posedge clk) disable iff (!rstn)
		((rise(r.s2.wgate, r.p.wgate) || rise(r.s2.rgate, r.p.rgate)) && !r.on_cyl)
		|=> r.fault[dsu_pkg::FR_OFFCYL])
		else $error("off cylinder gate not latched");

	a_seek_timeout: assert property (@(posedge clk) disable iff (!rstn)
		(r.seek == dsu_pkg::SK_MOVE && r.tmr == seek_lim &&
		!rise(r.s2.move_done, r.p.move_done)) |=> (r.seek_err && !r.on_cyl))
		else $error("move timeout did not flag seek error");

	a_rtz_clear: assert property (@(posedge clk) disable iff (!rstn)
		(r.seek == dsu_pkg::SK_IDLE && rise(r.s2.rtz, r.p.rtz) && !r.s2.eot)
		|=> (!r.seek_err && rtz_go && !r.on_cyl))
		else $error("zero seek did not clear error");

	a_eoc_wrap: assert property (@(posedge clk) disable iff (!rstn)
		(rise(r.s2.head_adv, r.p.head_adv) &&
		r.head_cnt > dsu_pkg::dsu_head_t'(dsu_pkg::HEAD_LAST)) |=> (r.head_cnt == '0))
		else $error("head advance at end of cylinder did not clear");

	a_amp_stretch: assert property (@(posedge clk) disable iff (!rstn)
		rise(r.s2.amp2, r.p.amp2) |=> (r.amp2_cnt != '0) [*8])
		else $error("amplitude dip stretch too short");

	a_amp_end: assert property (@(posedge clk) disable iff (!rstn)
		(rise(r.s2.amp3, r.p.amp3) ##1 !rise(r.s2.amp3, r.p.amp3) [*8])
		|-> ##[1:AMP_HOLD] (r.amp3_cnt == '0 || rise(r.s2.amp3, r.p.amp3)))
		else $error("amplitude dip stretch never ends");

	a_seek_ready: assert property (@(posedge clk) disable iff (!rstn)
		(!r.ready && r.seek == dsu_pkg::SK_IDLE && rise(r.s2.seek, r.p.seek) &&
		!rise(r.s2.rtz, r.p.rtz)) |=> (!seek_go && r.seek == dsu_pkg::SK_IDLE))
		else $error("seek taken while not ready");

	a_busy_sel: assert property (@(posedge clk) disable iff (!rstn)
		unit_selected |-> (!unit_busy && $past(r.s2.unit_sel) && $past(r.s2.online)))
		else $error("selected without select or while busy");

	a_release: assert property (@(posedge clk) disable iff (!rstn)
		(r.s2.rel_req && r.s2.unit_sel && r.res == dsu_pkg::RES_OURS)
		|=> (r.res != dsu_pkg::RES_OURS))
		else $error("release left reservation set");

	a_dis_opp: assert property (@(posedge clk) disable iff (!rstn)
		(r.s2.dis_opp && r.res == dsu_pkg::RES_OPP) |=> !unit_busy)
		else $error("disable opposite reserve did not free unit");

	a_oncyl_done: assert property (@(posedge clk) disable iff (!rstn)
		(r.seek == dsu_pkg::SK_MOVE && rise(r.s2.move_done, r.p.move_done))
		|=> (r.on_cyl && unit_ready))
		else $error("completed move did not show on cylinder");

	a_ready_drop: assert property (@(posedge clk) disable iff (!rstn)
		(r.s2.unload && r.s2.spin_off && r.seek == dsu_pkg::SK_IDLE)
		|=> !unit_ready)
		else $error("ready kept with heads unloaded");

	a_idle_bus: assert property (@(posedge clk) disable iff (!rstn)
		!r.selected |=> (status_bus == '0 && data_bus == '0))
		else $error("buses driven while not selected");

	a_wclk_idle: assert property (@(posedge clk) disable iff (!rstn)
		!r.s2.dd |=> !write_clock)
		else $error("write clock runs in single density");

	a_eot_flag: assert property (@(posedge clk) disable iff (!rstn)
		r.s2.eot |=> (r.seek_err && r.eot_err))
		else $error("end of travel did not flag seek error");
endmodule

// *** sim/dsu_ctl_model.sv ***
module dsu_ctl_model (
	input wire logic start,
	input wire logic [7:0] pattern,
	output logic wstrobe,
	output logic wdat_line,
	output logic frame_on
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================
	// Write frame toward the unit
	// ==================================================
	// Strobe runs at the link rate, not from the unit's write clock:
	// a clk/2 toggle is too fast to be sampled through two flops
	initial begin
		wstrobe = 1'h0;
		wdat_line = 1'h0;
		frame_on = 1'h0;
		forever begin
			@(posedge start);
			frame_on = 1'h1;
			// Step off the clock edge the frame was started on
			#20;
			// NRZ bits, high bit first, changed at strobe fall
			for (int i = 7; i >= 0; i--) begin
				wdat_line = pattern[i];
				#400 wstrobe = 1'h1;
				#400 wstrobe = 1'h0;
			end
			// Released line shows the inverse, never a stale bit
			wdat_line = ~wdat_line;
			frame_on = 1'h0;
		end
	end
endmodule

// *** sim/disk_unit_status_and_data_cable_test.sv ***
module disk_unit_status_and_data_cable_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================
	// Signals
	// ==================================================
	typedef struct packed {
		dsu_pkg::dsu_pins_t pins;
		dsu_pkg::dsu_word_t st;
		dsu_pkg::dsu_word_t dt;
		logic [1:0] rd;
	} dsu_row_t;
	localparam logic [2:0] SEL_SC = 3'h4;
	localparam logic [2:0] SEL_FS = 3'h2;
	localparam logic [2:0] SEL_CS = 3'h1;
	logic clk, rstn;
	dsu_pkg::dsu_pins_t p; // Bench-driven pins
	dsu_pkg::dsu_pins_t pins; // Pins with partner lines merged
	dsu_pkg::dsu_pins_t q; // Shadow of p, edited then driven
	dsu_pkg::dsu_pins_t m; // Mask for one pulse
	dsu_pkg::dsu_word_t status_bus, data_bus;
	logic unit_ready, unit_busy, unit_selected, on_line, read_data, ref_clock;
	logic write_clock, write_bit, dd_unit, seek_go, rtz_go, wc;
	logic [10:0] flags; // All single-bit outputs
	logic frm, m_strobe, m_wdat, m_fon;
	logic [7:0] pat;
	int num_errors, n_checks;
	int n_seek = 0, n_rtz = 0; // Start pulses seen
	dsu_row_t rows [7]; // One register select per row
	// ==================================================
	// Design and partner
	// ==================================================
	// Short move limit keeps the timeout case brief
	dsu_unit_if #(.SEEK_CYC_P(40), .SEEK_DD_CYC_P(46)) u_dut (
		.clk(clk), .rstn(rstn), .pins(pins), .status_bus(status_bus),
		.data_bus(data_bus), .unit_ready(unit_ready), .unit_busy(unit_busy),
		.unit_selected(unit_selected), .on_line(on_line), .read_data(read_data),
		.ref_clock(ref_clock), .write_clock(write_clock), .write_bit(write_bit),
		.dd_unit(dd_unit), .seek_go(seek_go), .rtz_go(rtz_go)
	);
	dsu_ctl_model u_ctl (
		.start(frm), .pattern(pat), .wstrobe(m_strobe), .wdat_line(m_wdat),
		.frame_on(m_fon)
	);
	assign flags = {unit_ready, unit_busy, unit_selected, on_line, read_data, ref_clock,
		write_clock, write_bit, dd_unit, seek_go, rtz_go};
	// Partner owns the write strobe and data lines
	always_comb begin
		pins = p;
		pins.wstrobe = m_strobe;
		pins.wdat_line = m_wdat;
	end
	// One-cycle start pulses are counted, not chased
	always @(posedge clk) begin
		if (seek_go === 1'h1) n_seek <= n_seek + 1;
		if (rtz_go === 1'h1) n_rtz <= n_rtz + 1;
	end
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// ==================================================
	// Tasks
	// ==================================================
	task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic drv(input dsu_pkg::dsu_pins_t v);
		@(posedge clk);
		p <= v;
	endtask
	// Pulses four cycles wide, enough for the two-flop sampling
	task automatic pls();
		drv(q | m);
		w(3);
		drv(q);
		w(3);
	endtask
	task automatic see(input logic [2:0] s);
		q.sel_sc = s[2];
		q.sel_fs = s[1];
		q.sel_cs = s[0];
		drv(q);
		w(6);
	endtask
	task automatic clrf();
		m = '0;
		m.clr_fault = 1'h1;
		pls();
	endtask
	task automatic frame(input logic [7:0] v);
		@(posedge clk);
		pat <= v;
		frm <= 1'h1;
		w(2);
		for (int k = 0; k < 200 && m_fon === 1'h1; k++) w(1);
		if (m_fon !== 1'h0) begin
			num_errors++;
			tally_and_finish();
		end
		@(posedge clk);
		frm <= 1'h0;
		w(6);
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Guard against a hang anywhere
	initial begin
		#3000000;
		num_errors++;
		tally_and_finish();
	end
	// ==================================================
	// Main sequence
	// ==================================================
	initial begin
		rstn = 1'h0;
		p = '0;
		q = '0;
		m = '0;
		frm = 1'h0;
		pat = 8'h00;
		num_errors = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		w(2);
		chk("reset flags", 18'(flags), 18'h0);
		chk("reset buses", {status_bus, data_bus}, 18'h0);
		q.unit_sel = 1'h1;
		q.online = 1'h1;
		drv(q);
		w(6);
		chk("select", {unit_selected, unit_busy, on_line}, 18'h5);
		// Plain seek before the first zero seek is ignored
		m = '0;
		m.seek = 1'h1;
		pls();
		chk("early seek", 18'(n_seek), 18'h0);
		m = '0;
		m.rtz = 1'h1;
		pls();
		m = '0;
		m.move_done = 1'h1;
		pls();
		chk("first seek", {unit_ready, 17'(n_rtz)}, 18'h20001);
		// Ordinary cases from the table
		for (int i = 0; i < 7; i++) rows[i] = '{pins: q, st: 9'h000, dt: 9'h000, rd: 2'h0};
		rows[0].pins.sel_ps = 1'h1;
		rows[0].pins.fwd = 1'h1;
		rows[0].dt = 9'h001;
		rows[1].pins.sel_ps = 1'h1;
		rows[1].pins.eot = 1'h1;
		rows[1].pins.fine = 1'h1;
		rows[1].pins.speed = 1'h1;
		rows[1].dt = 9'h03A;
		// End of travel also raises seek error, held until a zero seek
		rows[2].pins.sel_sr = 1'h1;
		rows[2].pins.sect_reg = 5'h15;
		rows[2].dt = 9'h015;
		rows[3].pins.sel_cs = 1'h1;
		rows[3].pins.rgate = 1'h1;
		rows[3].pins.rd_pulse = 1'h1;
		rows[3].pins.ref_clk = 1'h1;
		rows[3].st = 9'h00E;
		rows[3].rd = 2'h3;
		rows[4].pins.sel_fs = 1'h1;
		rows[4].pins.pvolt = 1'h1;
		rows[4].st = 9'h028;
		// Voltage fault is sticky and shows as unsafe
		rows[5].pins.sel_cs = 1'h1;
		rows[5].st = 9'h00E;
		rows[6].pins.sel_fs = 1'h1;
		rows[6].pins.nvolt = 1'h1;
		rows[6].st = 9'h038;
		foreach (rows[i]) begin
			drv(rows[i].pins);
			w(6);
			chk("row status", status_bus, rows[i].st);
			chk("row data", data_bus, rows[i].dt);
			chk("row read", {read_data, ref_clock}, rows[i].rd);
		end
		// Zero seek clears the travel error before the fault clear
		m = '0;
		m.rtz = 1'h1;
		pls();
		m = '0;
		m.move_done = 1'h1;
		pls();
		clrf();
		see(SEL_FS);
		chk("cleared", status_bus, 9'h000);
		// Move that never completes, with a gate while off cylinder
		m = '0;
		m.seek = 1'h1;
		pls();
		m = '0;
		m.rgate = 1'h1;
		pls();
		w(60);
		chk("seek started", 18'(n_seek), 18'h1);
		chk("fs timeout", status_bus, 9'h021);
		see(SEL_CS);
		chk("cs timeout", status_bus, 9'h006);
		m = '0;
		m.rtz = 1'h1;
		pls();
		m = '0;
		m.move_done = 1'h1;
		pls();
		chk("zero seek", status_bus, 9'h00A);
		clrf();
		// Write gate inside read gate, then a head fault
		q.rgate = 1'h1;
		q.wdata = 1'h1;
		see(SEL_FS);
		m = '0;
		m.wgate = 1'h1;
		pls();
		chk("write in read", status_bus, 9'h002);
		q.multi_head = 1'h1;
		drv(q);
		w(6);
		chk("multi head", status_bus, 9'h006);
		q = q & ~m;
		q.multi_head = 1'h0;
		q.rgate = 1'h0;
		q.wdata = 1'h0;
		clrf();
		chk("fault cleared", status_bus, 9'h000);
		// Sector counter leads by one and wraps after 23
		see(SEL_SC);
		m = '0;
		m.index = 1'h1;
		pls();
		w(2);
		chk("sector index", status_bus, 9'h101);
		m = '0;
		m.sect_pulse = 1'h1;
		for (int i = 0; i < 22; i++) pls();
		w(2);
		chk("sector last", status_bus, 9'h117);
		pls();
		w(2);
		chk("sector wrap", status_bus, 9'h100);
		// End of cylinder only beyond head 18
		see(SEL_CS);
		m = '0;
		m.head_adv = 1'h1;
		for (int i = 0; i < 18; i++) pls();
		chk("head 18", status_bus, 9'h008);
		pls();
		chk("head 19", status_bus, 9'h048);
		pls();
		chk("head wrap", status_bus, 9'h008);
		// Short dip must stand at least 5 us
		m = '0;
		m.amp2 = 1'h1;
		m.amp3 = 1'h1;
		pls();
		chk("dip seen", status_bus, 9'h188);
		// Last cycle of the 5 us stretch
		w(46);
		chk("dip held", status_bus, 9'h188);
		w(17);
		chk("dip gone", status_bus, 9'h008);
		// Double density write path with the partner
		q.dd = 1'h1;
		drv(q);
		w(6);
		chk("dd strap", 18'(dd_unit), 18'h1);
		wc = ~write_clock;
		w(1);
		chk("write clock", 18'(write_clock), 18'(wc));
		frame(8'hA5);
		chk("write bit one", 18'(write_bit), 18'h1);
		frame(8'h5A);
		chk("write bit zero", 18'(write_bit), 18'h0);
		q.dd = 1'h0;
		drv(q);
		w(6);
		chk("write clock idle", 18'(write_clock), 18'h0);
		// Reservation between channels
		q.rel_req = 1'h1;
		drv(q);
		w(6);
		chk("select release", {unit_selected, unit_busy}, 18'h2);
		q.unit_sel = 1'h0;
		q.rel_req = 1'h0;
		q.opp_sel = 1'h1;
		drv(q);
		w(6);
		chk("opposite busy", {unit_selected, unit_busy}, 18'h1);
		q.unit_sel = 1'h1;
		drv(q);
		w(6);
		chk("busy refuses", 18'(unit_selected), 18'h0);
		q.opp_sel = 1'h0;
		q.dis_opp = 1'h1;
		drv(q);
		w(6);
		chk("opposite freed", {unit_selected, unit_busy}, 18'h2);
		// Off-line unit drops its own selection while unit_sel stays high
		q.dis_opp = 1'h0;
		q.online = 1'h0;
		drv(q);
		w(6);
		chk("off line", {unit_selected, on_line}, 18'h0);
		// Heads unloaded with spindle stopped drop ready
		q.unload = 1'h1;
		q.spin_off = 1'h1;
		drv(q);
		w(6);
		chk("ready drop", 18'(unit_ready), 18'h0);
		// Second reset in mid-run, then released again
		@(posedge clk);
		rstn <= 1'h0;
		w(2);
		chk("mid reset", {status_bus, flags[10:2]}, 18'h0);
		@(posedge clk);
		rstn <= 1'h1;
		w(2);
		chk("after reset", {status_bus, flags[10:2]}, 18'h0);
		tally_and_finish();
	end
endmodule
